/* File: common/flash_cmd_regs.vh */
// opcodes, field positions, sizes and timing counts of the command block
`ifndef FLASH_CMD_REGS_VH
`define FLASH_CMD_REGS_VH
`define OP_SECTOR_ERASE 8'h7c
`define OP_PROG_BUF1 8'h82
`define OP_PROG_BUF2 8'h85
`define OP_CHIP_ERASE_B1 8'hc7
`define OP_CHIP_ERASE_B2 8'h94
`define OP_CHIP_ERASE_B3 8'h80
`define OP_CHIP_ERASE_B4 8'h9a
`define OP_PROT_B1 8'h3d
`define OP_PROT_B2 8'h2a
`define OP_PROT_B3 8'h7f
`define OP_PROT_EN_B4 8'ha9
`define OP_PROT_DIS_B4 8'h9a
`define PROT_BYTE_ON 8'hff
`define PROT_BYTE_OFF 8'h00
`define SECTOR_COUNT 16
`define BUF_BYTES_528 528
`define BUF_BYTES_512 512
`define BUF_ADDR_W 10
`define PAGE_ADDR_W 12
`define STATUS_BUSY_N_BIT 7
`define STATUS_PROT_BIT 1
`define STATUS_PAGE512_BIT 0
`define CLK_PERIOD_NS 5
`define SECTOR_ERASE_TIME_US 5000
`define CHIP_ERASE_TIME_US 40000
`define ERASE_PROGRAM_TIME_US 40
`define SECTOR_ERASE_CYCLES (`SECTOR_ERASE_TIME_US * 1000 / `CLK_PERIOD_NS)
`define CHIP_ERASE_CYCLES (`CHIP_ERASE_TIME_US * 1000 / `CLK_PERIOD_NS)
`define ERASE_PROGRAM_CYCLES (`ERASE_PROGRAM_TIME_US * 1000 / `CLK_PERIOD_NS)
`endif

/* File: core/flash_cmd_ctrl.v */
// serial command decoder and self-timed erase, program and protection control
`timescale 1ns/1ps
`include "flash_cmd_regs.vh"

// How it works
// - sector erase opcode erases exactly one sector
// - 528 mode: sector 0 uses nine page bits
// - 528 mode: sectors 1-15 use four bits
// - 512 mode: sector 0 uses address bits 20-12
// - 512 mode: sectors 1-15 use bits 20-17
// - any page inside a sector selects it
// - chip select rise starts erase, busy shown
// - four-byte chip erase, extra bytes ignored
// - chip erase starts on deselect, busy throughout
// - chip erase skips protected or locked sectors
// - pin protection waits for erase to finish
// - 528 mode program: twelve page, ten buffer bits
// - 512 mode program: nine buffer bits
// - data bytes fill buffer, wrapping to zero
// - deselect erases page, programs it, shows busy
// - status shows whether protection is enabled
// - sequence ending A9 enables protection on deselect
// - sequence ending 9A disables protection on deselect
// - disable ignored while write-protect pin asserted
// - protected sectors refuse program and erase
// - protection byte FF protects, 00 unprotects
module flash_cmd_ctrl #(
	parameter [31:0] SECTOR_ERASE_CYCLES = `SECTOR_ERASE_CYCLES,
	parameter [31:0] CHIP_ERASE_CYCLES = `CHIP_ERASE_CYCLES
) (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// serial link pins
	input wire cs_n,
	input wire sck,
	input wire si,
	input wire wp_n,
	// configuration and protection table
	input wire page512,
	input wire [127:0] prot_bytes,
	input wire [15:0] lock_map,
	// status
	output wire rdy_busy_n,
	output reg [7:0] status_r,
	// array operation requests to the flash core
	output reg op_valid_r,
	output reg [1:0] op_kind_r,
	output reg [11:0] op_page_r,
	output reg [15:0] op_sector_mask_r,
	output reg [1:0] op_sub0_r,
	output reg op_buf_sel_r,
	// buffer write port
	output reg buf_we_r,
	output reg buf_sel_r,
	output reg [9:0] buf_addr_r,
	output reg [7:0] buf_data_r
);
	localparam OPK_SECTOR = 2'd0;
	localparam OPK_CHIP = 2'd1;
	localparam OPK_PROG = 2'd2;

	localparam ST_IDLE = 2'd0;
	localparam ST_BUSY = 2'd1;

	localparam [1:0] CMD_NONE = 2'd0;
	localparam [1:0] CMD_SECT = 2'd1;
	localparam [1:0] CMD_PROG = 2'd2;
	localparam [1:0] CMD_SEQ = 2'd3;

	localparam [31:0] PROG_CYCLES = `ERASE_PROGRAM_CYCLES;

	wire cs_n_s;
	wire sck_s;
	wire si_s;
	wire wp_n_s;

	sync2 u_sync_cs (.core_clk(core_clk), .rst_n(rst_n), .din(~cs_n),
		.rst_val(1'b1), .dout(cs_n_s));
	sync2 u_sync_sck (.core_clk(core_clk), .rst_n(rst_n), .din(sck),
		.rst_val(1'b0), .dout(sck_s));
	sync2 u_sync_si (.core_clk(core_clk), .rst_n(rst_n), .din(si),
		.rst_val(1'b0), .dout(si_s));
	sync2 u_sync_wp (.core_clk(core_clk), .rst_n(rst_n), .din(~wp_n),
		.rst_val(1'b1), .dout(wp_n_s));

	reg sck_d_r;
	reg cs_n_d_r;
	reg [7:0] shift_r;
	reg [2:0] bit_cnt_r;
	reg [2:0] byte_cnt_r;
	reg [1:0] cmd_r;
	reg [7:0] op_r;
	reg [23:0] addr_r;
	reg seq_ok_r;
	reg [7:0] last_byte_r;
	reg frame_ok_r;
	reg soft_prot_r;
	reg wp_prot_r;
	reg [1:0] state_r;
	reg [31:0] timer_r;
	reg page512_r;

	wire sck_rise = sck_s & ~sck_d_r;
	wire cs_rise = cs_n_s & ~cs_n_d_r;
	wire selected = ~cs_n_s;
	wire [7:0] byte_in = {shift_r[6:0], si_s};
	wire byte_done = selected & sck_rise & (bit_cnt_r == 3'd7);
	wire busy = (state_r == ST_BUSY);
	wire wp_on = ~wp_n_s;
	wire prot_en = soft_prot_r | wp_prot_r;

	// page field from the address bytes in either page mode
	wire [11:0] page_sel = page512_r ? addr_r[20:9] : addr_r[21:10];

	// sector decode: sectors 1-15 from the top four page bits
	wire [3:0] sect_num = page_sel[11:8];
	wire sect0b = (sect_num == 4'd0) & (page_sel[7:3] != 5'd0);

	// per-sector protection from the table, sector 0 split in two halves
	reg [15:0] prot_map;
	reg [1:0] prot0;
	integer i;
	always @* begin
		prot_map = 16'h0000;
		prot0 = {prot_bytes[7] & prot_bytes[6], prot_bytes[5] & prot_bytes[4]};
		for (i = 1; i < `SECTOR_COUNT; i = i + 1) begin
			prot_map[i] = (prot_bytes[i*8 +: 8] == `PROT_BYTE_ON);
		end
	end

	wire target_prot = (sect_num != 4'd0) ? prot_map[sect_num] :
		(sect0b ? prot0[0] : prot0[1]);
	wire target_lock = lock_map[sect_num];
	wire target_refused = (prot_en & target_prot) | target_lock;

	wire [15:0] chip_mask = ~(lock_map |
		({16{prot_en}} & {prot_map[15:1], prot0[1] & prot0[0]}));

	always @(posedge core_clk) begin
		if (!rst_n) begin
			sck_d_r <= 1'b0;
			cs_n_d_r <= 1'b1;
			shift_r <= 8'h00;
			bit_cnt_r <= 3'd0;
			byte_cnt_r <= 3'd0;
			cmd_r <= CMD_NONE;
			op_r <= 8'h00;
			addr_r <= 24'h000000;
			seq_ok_r <= 1'b0;
			last_byte_r <= 8'h00;
			frame_ok_r <= 1'b0;
			buf_we_r <= 1'b0;
			buf_sel_r <= 1'b0;
			buf_addr_r <= 10'h000;
			buf_data_r <= 8'h00;
			page512_r <= 1'b0;
		end else begin
			sck_d_r <= sck_s;
			cs_n_d_r <= cs_n_s;
			buf_we_r <= 1'b0;
			if (!selected) begin
				// an empty select must not replay the last command
				frame_ok_r <= 1'b0;
				bit_cnt_r <= 3'd0;
				byte_cnt_r <= 3'd0;
				if (!busy)
					page512_r <= page512;
			end else if (sck_rise) begin
				shift_r <= byte_in;
				bit_cnt_r <= bit_cnt_r + 3'd1;
				if (byte_done) begin
					if (byte_cnt_r != 3'd7)
						byte_cnt_r <= byte_cnt_r + 3'd1;
					case (byte_cnt_r)
					3'd0: begin
						op_r <= byte_in;
						frame_ok_r <= 1'b0;
						seq_ok_r <= (byte_in == `OP_CHIP_ERASE_B1) |
							(byte_in == `OP_PROT_B1);
						if (byte_in == `OP_SECTOR_ERASE)
							cmd_r <= CMD_SECT;
						else if (byte_in == `OP_PROG_BUF1 ||
							byte_in == `OP_PROG_BUF2)
							cmd_r <= CMD_PROG;
						else if (byte_in == `OP_CHIP_ERASE_B1 ||
							byte_in == `OP_PROT_B1)
							cmd_r <= CMD_SEQ;
						else
							cmd_r <= CMD_NONE;
					end
					3'd1, 3'd2, 3'd3: begin
						addr_r <= {addr_r[15:0], byte_in};
						if (cmd_r == CMD_SEQ) begin
							// strict byte match; any mismatch kills it
							if (op_r == `OP_CHIP_ERASE_B1)
								seq_ok_r <= seq_ok_r & ((byte_cnt_r == 3'd1) ?
									byte_in == `OP_CHIP_ERASE_B2 :
									(byte_cnt_r == 3'd2) ?
									byte_in == `OP_CHIP_ERASE_B3 :
									byte_in == `OP_CHIP_ERASE_B4);
							else
								seq_ok_r <= seq_ok_r & ((byte_cnt_r == 3'd1) ?
									byte_in == `OP_PROT_B2 :
									(byte_cnt_r == 3'd2) ?
									byte_in == `OP_PROT_B3 :
									(byte_in == `OP_PROT_EN_B4 ||
									byte_in == `OP_PROT_DIS_B4));
						end
						if (byte_cnt_r == 3'd3) begin
							last_byte_r <= byte_in;
							frame_ok_r <= 1'b1;
							if (cmd_r == CMD_PROG) begin
								buf_sel_r <= (op_r == `OP_PROG_BUF2);
								// first buffer location from the low address bits
								buf_addr_r <= page512_r ?
									{1'b0, addr_r[0], byte_in} :
									{addr_r[1:0], byte_in};
							end
						end
					end
					default: begin
						// extra bytes after a sequence are dropped
						if (cmd_r == CMD_PROG && !busy) begin
							buf_we_r <= 1'b1;
							buf_data_r <= byte_in;
						end
					end
					endcase
				end
			end
			// advance after each stored byte, wrapping at the buffer end
			if (buf_we_r) begin
				if (buf_addr_r == (page512_r ? 10'd511 : 10'd527))
					buf_addr_r <= 10'h000;
				else
					buf_addr_r <= buf_addr_r + 10'd1;
			end
		end
	end

	// deselect after a whole frame launches the operation
	wire frame_end = cs_rise & frame_ok_r & (bit_cnt_r == 3'd0);
	wire seq_chip = (cmd_r == CMD_SEQ) & seq_ok_r &
		(op_r == `OP_CHIP_ERASE_B1);
	wire seq_en = (cmd_r == CMD_SEQ) & seq_ok_r & (op_r == `OP_PROT_B1) &
		(last_byte_r == `OP_PROT_EN_B4);
	wire seq_dis = (cmd_r == CMD_SEQ) & seq_ok_r & (op_r == `OP_PROT_B1) &
		(last_byte_r == `OP_PROT_DIS_B4);

	always @(posedge core_clk) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			timer_r <= 32'd0;
			op_valid_r <= 1'b0;
			op_kind_r <= OPK_SECTOR;
			op_page_r <= 12'h000;
			op_sector_mask_r <= 16'h0000;
			op_sub0_r <= 2'b00;
			op_buf_sel_r <= 1'b0;
			soft_prot_r <= 1'b0;
			wp_prot_r <= 1'b0;
			status_r <= 8'h80;
		end else begin
			op_valid_r <= 1'b0;
			// pin protection is held off while an erase is in progress
			if (!busy)
				wp_prot_r <= wp_on;
			case (state_r)
			ST_IDLE: begin
				if (frame_end && cmd_r == CMD_SECT && !target_refused) begin
					state_r <= ST_BUSY;
					timer_r <= SECTOR_ERASE_CYCLES;
					op_valid_r <= 1'b1;
					op_kind_r <= OPK_SECTOR;
					op_page_r <= page_sel;
					// one-hot mask: only one sector per command
					op_sector_mask_r <= 16'h0001 << sect_num;
					op_sub0_r <= (sect_num != 4'd0) ? 2'b00 :
						(sect0b ? 2'b01 : 2'b10);
				end else if (frame_end && cmd_r == CMD_PROG &&
					!target_refused) begin
					state_r <= ST_BUSY;
					timer_r <= PROG_CYCLES;
					op_valid_r <= 1'b1;
					op_kind_r <= OPK_PROG;
					op_page_r <= page_sel;
					op_buf_sel_r <= buf_sel_r;
				end else if (frame_end && seq_chip) begin
					state_r <= ST_BUSY;
					timer_r <= CHIP_ERASE_CYCLES;
					op_valid_r <= 1'b1;
					op_kind_r <= OPK_CHIP;
					op_sector_mask_r <= chip_mask;
					// mask bit 0 covers both halves; this keeps a guarded half
					op_sub0_r <= ~({2{prot_en}} & prot0) & {2{~lock_map[0]}};
				end else if (frame_end && seq_en) begin
					soft_prot_r <= 1'b1;
				end else if (frame_end && seq_dis && !wp_on) begin
					soft_prot_r <= 1'b0;
				end
			end
			ST_BUSY: begin
				if (timer_r <= 32'd1)
					state_r <= ST_IDLE;
				timer_r <= timer_r - 32'd1;
			end
			default: state_r <= ST_IDLE;
			endcase
			// status byte: ready in bit 7, protection in bit 1, page size in bit 0
			status_r <= {~busy, 5'b00000, prot_en, page512_r};
		end
	end

	assign rdy_busy_n = ~busy;
endmodule // flash_cmd_ctrl

/* File: core/sync2.v */
// two flip-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module sync2 (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// level in and out
	input wire din,
	input wire rst_val,
	output wire dout
);
	reg meta_r;
	reg stable_r;

	always @(posedge core_clk) begin
		if (!rst_n) begin
			meta_r <= 1'b0;
			stable_r <= 1'b0;
		end else begin
			meta_r <= din;
			stable_r <= meta_r;
		end
	end

	// rst_val kept for callers that want an idle-high line inverted outside
	assign dout = stable_r ^ rst_val;
endmodule // sync2

/* File: sim/flash_cmd_ctrl_monitor.sv */
// assertion checker for the flash command block ports
`timescale 1ns/1ps
module flash_cmd_ctrl_monitor #(
	parameter [31:0] SECTOR_ERASE_CYCLES = 32'd20,
	parameter [31:0] CHIP_ERASE_CYCLES = 32'd20
) (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// pins and configuration
	input wire wp_n,
	input wire page512,
	input wire [15:0] lock_map,
	// status and launch
	input wire rdy_busy_n,
	input wire [7:0] status_r,
	input wire op_valid_r,
	input wire [1:0] op_kind_r,
	input wire [15:0] op_sector_mask_r,
	// buffer writes
	input wire buf_we_r,
	input wire [9:0] buf_addr_r
);
	reg [31:0] bcnt_r;
	wire [31:0] lim;
	assign lim = op_kind_r == 2'd0 ? SECTOR_ERASE_CYCLES : CHIP_ERASE_CYCLES;
	// busy cycles since launch
	always @(posedge core_clk) begin
		if (!rst_n || op_valid_r)
			bcnt_r <= 32'h0;
		else if (!rdy_busy_n)
			bcnt_r <= bcnt_r + 32'h1;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	property p_launch; op_valid_r |-> !rdy_busy_n; endproperty
	a_launch: assert property (p_launch)
		else $error("not busy at launch");
	property p_stat; 1'b1 |=> status_r[7] == $past(rdy_busy_n); endproperty
	a_stat: assert property (p_stat)
		else $error("status busy bit wrong");
	property p_one;
		op_valid_r && op_kind_r == 2'd0 |-> $onehot(op_sector_mask_r);
	endproperty
	a_one: assert property (p_one)
		else $error("sector mask not one-hot");
	property p_time;
		$rose(rdy_busy_n) && op_kind_r != 2'd2 |->
			bcnt_r + 32'd2 >= lim && bcnt_r <= lim + 32'd1;
	endproperty
	a_time: assert property (p_time)
		else $error("erase busy length wrong");
	property p_dis; $fell(status_r[1]) |-> wp_n; endproperty
	a_dis: assert property (p_dis)
		else $error("protection dropped with pin low");
	property p_wait;
		!rdy_busy_n && $past(!rdy_busy_n) && $past(!rdy_busy_n, 2) |->
			!$rose(status_r[1]);
	endproperty
	a_wait: assert property (p_wait)
		else $error("protection rose while busy");
	property p_lock;
		op_valid_r && op_kind_r == 2'd1 |-> (op_sector_mask_r & lock_map) == 16'h0;
	endproperty
	a_lock: assert property (p_lock)
		else $error("chip erase hits locked sector");
	property p_wrap;
		buf_we_r |-> buf_addr_r < (page512 ? 10'd512 : 10'd528);
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("buffer address past end");
	c_sec: cover property (op_valid_r && op_kind_r == 2'd0);
	c_chip: cover property (op_valid_r && op_kind_r == 2'd1);
	c_prog: cover property (op_valid_r && op_kind_r == 2'd2);
endmodule // flash_cmd_ctrl_monitor

/* File: sim/spi_host.sv */
// host serial master model driving select, clock and data
`timescale 1ns/1ps
module spi_host (
	// serial pins
	output logic cs_n,
	output logic sck,
	output logic si
);
	logic [7:0] q[$];
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end
	// clock rests low between frames; nbits may cut the last byte short
	task automatic frame(input int nbits);
		#20 cs_n = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			si = q[i / 8][7 - i % 8];
			#32 sck = 1'b1;
			#32 sck = 1'b0;
		end
		#32 cs_n = 1'b1;
		si = ~si;
		q.delete();
	endtask
endmodule // spi_host

/* File: sim/test_serial_flash_erase_protect_cmds.sv */
// self-checking bench for the serial flash command block
`timescale 1ns/1ps
module test_serial_flash_erase_protect_cmds;
	logic core_clk, rst_n, wp_n, page512;
	logic [127:0] prot_bytes;
	logic [15:0] lock_map, pm;
	logic [11:0] pg;
	logic [31:0] r;
	logic [9:0] ba;
	logic [7:0] dq[$];
	logic [17:0] wq[$];
	wire cs_n, sck, si, rdy_busy_n, op_valid_r, op_buf_sel_r, buf_we_r;
	wire [7:0] status_r, buf_data_r;
	wire [1:0] op_kind_r, op_sub0_r;
	wire [11:0] op_page_r;
	wire [15:0] op_sector_mask_r;
	wire [9:0] buf_addr_r;
	wire buf_sel_r;
	int miscompares, n_checks;
	spi_host host(.cs_n, .sck, .si);
	flash_cmd_ctrl #(.SECTOR_ERASE_CYCLES(32'd20), .CHIP_ERASE_CYCLES(32'd20))
		dut(.core_clk, .rst_n, .cs_n, .sck, .si, .wp_n, .page512, .prot_bytes,
		.lock_map, .rdy_busy_n, .status_r, .op_valid_r, .op_kind_r, .op_page_r,
		.op_sector_mask_r, .op_sub0_r, .op_buf_sel_r, .buf_we_r,
		.buf_sel_r, .buf_addr_r, .buf_data_r);
	always @(posedge core_clk)
		if (buf_we_r) wq.push_back({buf_addr_r, buf_data_r});
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic go(input int nbits, input logic op);
		host.frame(nbits);
		for (int i = 0; i < 40 && op_valid_r !== 1'b1; i++) @(negedge core_clk);
		chk(op_valid_r, op);
	endtask
	task automatic idle();
		for (int i = 0; i < 9000 && rdy_busy_n !== 1'b1; i++) @(negedge core_clk);
		repeat (3) @(negedge core_clk);
	endtask
	task automatic cmd(input logic [7:0] b4, input int nb, input logic e);
		host.q = {8'h3d, 8'h2a, 8'h7f, b4};
		go(nb, 1'b0);
		idle();
		chk(status_r[1], e);
	endtask
	// opcode, page, buffer start, then nd random data bytes
	task automatic send(input logic [7:0] opc, input logic [11:0] p,
		input logic [9:0] b, input int nd, input logic op);
		@(negedge core_clk); // a page size change lands on the edge first
		r = $urandom;
		r[23:0] = page512 ? {r[23:21], p, b[8:0]} : {r[23:22], p, b};
		host.q = {opc, r[23:16], r[15:8], r[7:0]};
		repeat (nd) host.q.push_back(8'($urandom));
		dq = host.q;
		go(32 + 8 * nd, op);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	initial begin
		#400000;
		miscompares++;
		conclude();
	end
	initial begin
		rst_n = 1'b0;
		wp_n = 1'b1;
		page512 = 1'b0;
		prot_bytes = 128'h0;
		lock_map = 16'h0;
		void'($urandom(14757));
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(negedge core_clk);
		chk(status_r, 32'h80);
		for (int k = 0; k < 12; k++) begin
			r = $urandom;
			pg = k % 6 == 0 ? {9'h0, r[2:0]} : k % 6 == 1 ? {4'h0, r[7:0] | 8'h08}
				: k % 6 == 5 ? 12'hfff : {r[11:8] | 4'h1, r[7:0]};
			@(posedge core_clk) page512 <= (k > 5);
			send(8'h7c, pg, 10'(r[31:22]), 0, 1'b1);
			chk(op_kind_r, 0);
			chk(op_page_r, pg);
			chk(op_sector_mask_r, 16'h1 << pg[11:8]);
			if (pg[11:8] == 0) chk(op_sub0_r, pg[7:3] == 0 ? 2 : 1);
			chk(rdy_busy_n, 0);
			idle();
		end
		@(posedge core_clk) lock_map <= 16'($urandom) & 16'h7ffe;
		host.q = {8'hc7, 8'h94, 8'h80, 8'h9a, 8'h55};
		go(40, 1'b1);
		chk(op_kind_r, 1);
		chk(op_sector_mask_r, 16'(~lock_map));
		chk(op_sub0_r, 2'b11);
		@(posedge core_clk) wp_n <= 1'b0;
		repeat (8) @(negedge core_clk);
		chk(status_r[1], 0);
		idle();
		chk(status_r[1], 1);
		cmd(8'ha9, 32, 1'b1);
		cmd(8'h9a, 32, 1'b1);
		@(posedge core_clk) wp_n <= 1'b1;
		cmd(8'h9b, 32, 1'b1);
		cmd(8'h9a, 31, 1'b1);
		cmd(8'h9a, 32, 1'b0);
		cmd(8'ha9, 32, 1'b1);
		pm = (16'($urandom) | 16'h0020) & 16'hfffe;
		@(posedge core_clk);
		for (int s = 0; s < 16; s++) prot_bytes[8*s +: 8] <= pm[s] ? 8'hff : 8'h00;
		prot_bytes[7:0] <= 8'hc0; // only half 0a guarded
		send(8'h7c, 12'h5a3, 10'h0, 0, 1'b0);
		host.q = {8'hc7, 8'h94, 8'h80, 8'h9a};
		go(32, 1'b1);
		chk(op_sector_mask_r, 16'(~lock_map & ~pm));
		chk(op_sub0_r, 2'b01);
		idle();
		cmd(8'h9a, 32, 1'b0);
		@(posedge core_clk) lock_map <= 16'h0;
		for (int m = 0; m < 2; m++) begin
			@(posedge core_clk) page512 <= m[0];
			pg = 12'($urandom);
			ba = m ? 10'd510 : 10'd526;
			wq.delete();
			send(m ? 8'h85 : 8'h82, pg, ba, 4, 1'b1);
			chk(op_kind_r, 2);
			chk(op_page_r, pg);
			chk(op_buf_sel_r, m);
			chk(buf_sel_r, m);
			chk(rdy_busy_n, 0);
			for (int i = 0; i < 4; i++)
				chk(wq[i], {10'((ba + i) % (m ? 512 : 528)), dq[4 + i]});
			idle();
		end
		conclude();
	end
endmodule // test_serial_flash_erase_protect_cmds
bind flash_cmd_ctrl flash_cmd_ctrl_monitor #(
	.SECTOR_ERASE_CYCLES(SECTOR_ERASE_CYCLES),
	.CHIP_ERASE_CYCLES(CHIP_ERASE_CYCLES)
) mon (.core_clk, .rst_n, .wp_n, .page512, .lock_map, .rdy_busy_n,
	.status_r, .op_valid_r, .op_kind_r, .op_sector_mask_r, .buf_we_r,
	.buf_addr_r);
